// [core/pdtlp_timer.sv]
/*
  Prescaled 8-bit down timer with control register, interrupt arbitration
  toward the core and stop and wait handling, reached over AXI4-Lite.
  Assumes one clock at 25 MHz, synchronous active-low reset, an asynchronous
  timer pin, and a core that drives its own instruction flow.
*/
// Decided for this implementation: the AXI4-Lite slave port and the address map.
`include "pdtlp_consts.svh"
// Summary of operation
// - Eight-bit preloadable down counter, seven-bit prescaler
// - Count one to zero sets request flag
// - Interrupt only when both masks clear
// - Timer vector 7F8, from wait 7F6
// - Counter wraps after zero, keeps counting
// - Counter read stable, does not disturb
// - Flag sticky until software clears it
// - Divide select picks ratio 1 to 128
// - Bit 3 write clears prescaler, reads zero
// - Mode 00 counts instruction clock, also in wait
// - Mode 01 pin-gated clock; mode 10 disabled
// - Mode 11 counts pin falling edges
// - Flag set by zero or write, cleared likewise
// - Mask set by reset, stop or write
// - Select bits survive reset; bit 3 write-only
// - Count undefined after power-on, held through stop
// - Stop freezes timer until external request, wait write or reset
// - Stop clears global mask and flag, sets timer mask
// - Wait keeps timer, clears global mask
// - External wins; timer then uses normal vector
// - Software interrupt ignores mask, vector 7FC
// - Reset vectors 7FE and sets global mask
// - Global mask blocks, requests stay latched
module pdtlp_timer (
  // Clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // AXI4-Lite write
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  output logic [1:0]       s_axi_bresp,
  // AXI4-Lite read
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  input  wire logic [7:0]  s_axi_araddr,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  // Timer pin
  input  wire logic        timer_pin,
  // Core side
  output logic             timer_irq,
  output logic [11:0]      irq_vector,
  output logic             irq_vector_valid,
  output logic             core_clock_run
);
  pdtlp_pkg::pdtlp_state_type q, d;

  logic       wr_go;
  logic       rd_go;
  logic       tick_in;
  logic       tap;
  logic [7:0] cdata;
  logic [7:0] core_data;
  logic [7:0] presc_nx;
  logic       pin_fall;
  logic       core_wr;

  assign s_axi_awready = !q.awv && !q.bvalid;
  assign s_axi_wready  = !q.wv && !q.bvalid;
  assign s_axi_arready = !q.rvalid;
  assign s_axi_bvalid  = q.bvalid;
  assign s_axi_bresp   = q.bresp;
  assign s_axi_rvalid  = q.rvalid;
  assign s_axi_rdata   = q.rdata;
  assign s_axi_rresp   = q.rresp;
  assign irq_vector       = q.vector;
  assign irq_vector_valid = q.vec_valid;
  // Stop halts everything; wait halts the core but not the timer
  assign core_clock_run   = (q.mode == pdtlp_pkg::PDTLP_RUN);
  assign timer_irq = q.req && !q.mask && !q.imask;

  assign wr_go    = q.awv && q.wv && !q.bvalid;
  assign rd_go    = s_axi_arvalid && !q.rvalid;
  assign pin_fall = q.pin_s3 && !q.pin_s2;
  assign core_wr  = wr_go && q.awa[7:2] == `PDTLP_OFF_CORE >> 2 && q.ws[0];
  assign cdata    = {q.req, q.mask, q.src, q.pin_en, 1'b0, q.div};
  assign core_data = {2'b00, q.ext_pend, q.swi_pend, q.imask, 1'b0, q.mode};

  always_comb begin
    // Input selection; stop freezes the whole chain
    unique case ({q.src, q.pin_en})
      2'b00:   tick_in = 1'b1;
      2'b01:   tick_in = q.pin_s2;
      2'b10:   tick_in = 1'b0;
      default: tick_in = pin_fall;
    endcase
    if (q.mode == pdtlp_pkg::PDTLP_STOP) begin
      tick_in = 1'b0;
    end
  end

  always_comb begin
    // A tap pulses when every lower prescaler bit is one at a step
    presc_nx = {1'b0, q.presc} + 8'h01;
    tap = tick_in;
    for (int i = 0; i < 7; i++) begin
      if (i < int'(q.div)) begin
        tap = tap & q.presc[i];
      end
    end
  end

  always_comb begin
    d = q;
    d.pin_s1 = timer_pin;
    d.pin_s2 = q.pin_s1;
    d.pin_s3 = q.pin_s2;
    if (s_axi_awvalid && s_axi_awready) begin
      d.awv = 1'b1;
      d.awa = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      d.wv = 1'b1;
      d.wd = s_axi_wdata;
      d.ws = s_axi_wstrb;
    end
    if (s_axi_bvalid && s_axi_bready) begin
      d.bvalid = 1'b0;
    end
    if (s_axi_rvalid && s_axi_rready) begin
      d.rvalid = 1'b0;
    end

    // Prescaler and counter
    if (tick_in) begin
      d.presc = presc_nx[6:0];
    end
    if (tap) begin
      d.count = q.count - 8'h01;
      if (q.count == 8'h01) begin
        d.req = 1'b1;
      end
    end
    if (q.mode == pdtlp_pkg::PDTLP_STOP) begin
      // Leaving stop needs an external request or a core write with the wait bit
      if (q.ext_pend) begin
        d.mode = pdtlp_pkg::PDTLP_RUN;
      end
    end else if (q.mode == pdtlp_pkg::PDTLP_WAIT && (q.ext_pend || (q.req && !q.mask))) begin
      d.mode = pdtlp_pkg::PDTLP_RUN;
    end

    // Register writes; hardware flag set wins over a control register clear, not over stop entry
    d.bresp = `PDTLP_RESP_OKAY;
    if (wr_go) begin
      d.awv = 1'b0;
      d.wv = 1'b0;
      d.bvalid = 1'b1;
      if (q.awa[7:2] == `PDTLP_OFF_CONTROL >> 2 && q.ws[0]) begin
        d.req    = q.wd[`PDTLP_BIT_REQ] || (tap && q.count == 8'h01);
        d.mask   = q.wd[`PDTLP_BIT_MASK];
        d.src    = q.wd[`PDTLP_BIT_SRC];
        d.pin_en = q.wd[`PDTLP_BIT_PIN];
        d.div    = q.wd[2:0];
        if (q.wd[`PDTLP_BIT_PCLR]) begin
          d.presc = 7'h00;
        end
      end else if (q.awa[7:2] == `PDTLP_OFF_COUNTER >> 2 && q.ws[0]) begin
        d.count = q.wd[7:0];
      end else if (q.awa[7:2] == `PDTLP_OFF_CORE >> 2 && q.ws[0]) begin
        if (q.wd[`PDTLP_CORE_STOP]) begin
          d.mode  = pdtlp_pkg::PDTLP_STOP;
          d.imask = 1'b0;
          d.req   = 1'b0;
          d.mask  = 1'b1;
        end else if (q.wd[`PDTLP_CORE_WAIT]) begin
          d.mode  = pdtlp_pkg::PDTLP_WAIT;
          d.imask = 1'b0;
        end else begin
          d.imask = q.wd[`PDTLP_CORE_IMASK];
        end
        if (q.wd[`PDTLP_CORE_SWI]) begin
          d.swi_pend = 1'b1;
        end
        if (q.wd[`PDTLP_CORE_EXTREQ]) begin
          d.ext_pend = 1'b1;
        end
        if (q.wd[`PDTLP_CORE_ACK]) begin
          d.vec_valid = 1'b0;
        end
      end else if (q.awa[7:2] != `PDTLP_OFF_VECTOR >> 2) begin
        d.bresp = `PDTLP_RESP_SLVERR;
      end else begin
        d.bresp = `PDTLP_RESP_SLVERR;
      end
    end

    // Vector arbitration: swi, then external, then timer
    if (!q.vec_valid && q.mode != pdtlp_pkg::PDTLP_STOP) begin
      if (q.swi_pend) begin
        // A request written in this very cycle must survive the service
        d.vector    = `PDTLP_VEC_SWI;
        d.vec_valid = 1'b1;
        d.swi_pend  = core_wr && q.wd[`PDTLP_CORE_SWI];
        d.imask     = 1'b1;
      end else if (q.ext_pend && !q.imask) begin
        d.vector    = `PDTLP_VEC_EXT;
        d.vec_valid = 1'b1;
        d.ext_pend  = core_wr && q.wd[`PDTLP_CORE_EXTREQ];
        d.imask     = 1'b1;
        d.mode      = pdtlp_pkg::PDTLP_RUN;
      end else if (timer_irq) begin
        // Wait vector only while still waiting
        d.vector    = (q.mode == pdtlp_pkg::PDTLP_WAIT) ? `PDTLP_VEC_WAIT_TIMER : `PDTLP_VEC_TIMER;
        d.vec_valid = 1'b1;
        d.imask     = 1'b1;
        d.mode      = pdtlp_pkg::PDTLP_RUN;
      end
    end

    // Reads return registered copies, count unaffected
    if (rd_go) begin
      d.rvalid = 1'b1;
      d.rresp  = `PDTLP_RESP_OKAY;
      d.rdata  = 32'h0000_0000;
      unique case (s_axi_araddr[7:2])
        `PDTLP_OFF_CONTROL >> 2: d.rdata[7:0] = cdata;
        `PDTLP_OFF_COUNTER >> 2: d.rdata[7:0] = q.count;
        `PDTLP_OFF_CORE >> 2:    d.rdata[7:0] = core_data;
        `PDTLP_OFF_VECTOR >> 2:  d.rdata[12:0] = {q.vec_valid, q.vector};
        default:                 d.rresp = `PDTLP_RESP_SLVERR;
      endcase
    end

    if (!aresetn) begin
      // Select bits, prescaler and count are left alone
      d.awv       = 1'b0;
      d.wv        = 1'b0;
      d.bvalid    = 1'b0;
      d.rvalid    = 1'b0;
      d.req       = `PDTLP_RST_REQ;
      d.mask      = `PDTLP_RST_MASK;
      d.imask     = `PDTLP_RST_IMASK;
      d.ext_pend  = 1'b0;
      d.swi_pend  = 1'b0;
      d.mode      = pdtlp_pkg::PDTLP_RUN;
      d.vector    = `PDTLP_VEC_RESET;
      d.vec_valid = 1'b1;
    end
  end

  // Reset is synchronous and sits inside the next-state logic; count is
  // not reinitialised, so it is undefined after power-up and held through stop
  always_ff @(posedge aclk) begin
    q <= d;
  end

  AST_FLAG_SET: assert property (@(posedge aclk) disable iff (!aresetn)
    (tap && q.count == 8'h01) |=> q.req)
    else $error("Request flag not set at zero");
  sequence seq_stop_entered;
    $rose(q.mode == pdtlp_pkg::PDTLP_STOP);
  endsequence
  sequence seq_timer_alone;
    !q.vec_valid && !q.swi_pend && !q.ext_pend && timer_irq;
  endsequence

  AST_IRQ: assert property (@(posedge aclk) disable iff (!aresetn)
    (seq_timer_alone ##0 q.mode != pdtlp_pkg::PDTLP_STOP) |=> (q.vec_valid && q.imask))
    else $error("Timer interrupt not taken");
  AST_WRAP: assert property (@(posedge aclk) disable iff (!aresetn)
    (tap && q.count == 8'h00 && !wr_go) |=> q.count == 8'hFF)
    else $error("Counter did not wrap");
  AST_STEP: assert property (@(posedge aclk) disable iff (!aresetn)
    (!tap && !wr_go) |=> q.count == $past(q.count))
    else $error("Counter moved without tap");
  AST_STOP_FREEZE: assert property (@(posedge aclk) disable iff (!aresetn)
    (q.mode == pdtlp_pkg::PDTLP_STOP) |-> !tick_in)
    else $error("Timer ran in stop");
  AST_STOP_BITS: assert property (@(posedge aclk) disable iff (!aresetn)
    seq_stop_entered |-> (q.mask && !q.req))
    else $error("Stop did not mask timer");
  AST_STOP_IMASK: assert property (@(posedge aclk) disable iff (!aresetn)
    seq_stop_entered |-> !q.imask)
    else $error("Stop left global mask set");
  AST_PCLR_READ: assert property (@(posedge aclk) disable iff (!aresetn)
    (rd_go && s_axi_araddr[7:2] == `PDTLP_OFF_CONTROL >> 2) |=> q.rdata[`PDTLP_BIT_PCLR] == 1'b0)
    else $error("Bit 3 read nonzero");
  AST_WAIT_VEC: assert property (@(posedge aclk) disable iff (!aresetn)
    (seq_timer_alone ##0 q.mode == pdtlp_pkg::PDTLP_WAIT)
    |=> (q.vector == `PDTLP_VEC_WAIT_TIMER && q.vec_valid))
    else $error("Wait timer vector wrong");
  AST_SWI: assert property (@(posedge aclk) disable iff (!aresetn)
    (!q.vec_valid && q.swi_pend && q.mode != pdtlp_pkg::PDTLP_STOP) |=> q.vector == `PDTLP_VEC_SWI)
    else $error("Software interrupt vector wrong");
  AST_TIMER_NORMAL: assert property (@(posedge aclk) disable iff (!aresetn)
    (seq_timer_alone ##0 q.mode == pdtlp_pkg::PDTLP_RUN) |=> q.vector == `PDTLP_VEC_TIMER)
    else $error("Timer vector wrong in run");
  AST_EXT_FIRST: assert property (@(posedge aclk) disable iff (!aresetn)
    (!q.vec_valid && !q.swi_pend && q.ext_pend && !q.imask && q.mode != pdtlp_pkg::PDTLP_STOP)
    |=> q.vector == `PDTLP_VEC_EXT)
    else $error("External request not served first");
  AST_REQ_HOLD: assert property (@(posedge aclk) disable iff (!aresetn)
    (q.req && !wr_go) |=> q.req)
    else $error("Request flag dropped by itself");
  AST_MASK_HOLD: assert property (@(posedge aclk) disable iff (!aresetn)
    (q.mask && !wr_go) |=> q.mask)
    else $error("Timer mask dropped by itself");
  AST_INTERNAL: assert property (@(posedge aclk) disable iff (!aresetn)
    (!q.src && !q.pin_en && q.mode != pdtlp_pkg::PDTLP_STOP) |-> tick_in)
    else $error("Internal clock not counted");
  AST_WAIT_TIMER: assert property (@(posedge aclk) disable iff (!aresetn)
    (q.mode == pdtlp_pkg::PDTLP_WAIT) |-> (!core_clock_run && (tick_in || q.src || q.pin_en)))
    else $error("Wait stopped the timer");
  AST_GATED: assert property (@(posedge aclk) disable iff (!aresetn)
    (!q.src && q.pin_en && q.mode != pdtlp_pkg::PDTLP_STOP) |-> tick_in == q.pin_s2)
    else $error("Gated input wrong");
  AST_DISABLED: assert property (@(posedge aclk) disable iff (!aresetn)
    (q.src && !q.pin_en) |-> !tick_in)
    else $error("Disabled input counted");
  AST_PIN_EDGE: assert property (@(posedge aclk) disable iff (!aresetn)
    (q.src && q.pin_en && q.mode != pdtlp_pkg::PDTLP_STOP) |-> tick_in == (q.pin_s3 && !q.pin_s2))
    else $error("Pin edge not counted");
  AST_TAP_GATE: assert property (@(posedge aclk) disable iff (!aresetn)
    tap |-> tick_in)
    else $error("Tap without input tick");
  AST_TAP_DIV0: assert property (@(posedge aclk) disable iff (!aresetn)
    (q.div == 3'h0) |-> tap == tick_in)
    else $error("Divide by one wrong");
  AST_PCLR: assert property (@(posedge aclk) disable iff (!aresetn)
    (wr_go && q.awa[7:2] == `PDTLP_OFF_CONTROL >> 2 && q.ws[0] && q.wd[`PDTLP_BIT_PCLR])
    |=> q.presc == 7'h00)
    else $error("Prescaler not cleared");
  AST_PRELOAD: assert property (@(posedge aclk) disable iff (!aresetn)
    (wr_go && q.awa[7:2] == `PDTLP_OFF_COUNTER >> 2 && q.ws[0]) |=> q.count == $past(q.wd[7:0]))
    else $error("Counter preload lost");
  AST_READ_COUNT: assert property (@(posedge aclk) disable iff (!aresetn)
    (rd_go && s_axi_araddr[7:2] == `PDTLP_OFF_COUNTER >> 2) |=> q.rdata[7:0] == $past(q.count))
    else $error("Counter read wrong");
  AST_STOP_HOLD: assert property (@(posedge aclk) disable iff (!aresetn)
    (q.mode == pdtlp_pkg::PDTLP_STOP && !q.ext_pend && !wr_go) |=> q.mode == pdtlp_pkg::PDTLP_STOP)
    else $error("Stop left without request");
  AST_STOP_EXIT: assert property (@(posedge aclk) disable iff (!aresetn)
    (q.mode == pdtlp_pkg::PDTLP_STOP && q.ext_pend && !wr_go) |=> q.mode == pdtlp_pkg::PDTLP_RUN)
    else $error("Stop not left on request");
  AST_VEC_IMASK: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(q.vec_valid) |-> q.imask)
    else $error("Vector taken with mask open");
  AST_LATCHED: assert property (@(posedge aclk) disable iff (!aresetn)
    (q.imask && q.ext_pend) |=> q.ext_pend)
    else $error("Masked request lost");
  // No disable here: the reset cycle itself is what is watched
  AST_RESET_VEC: assert property (@(posedge aclk)
    !aresetn |=> (q.vector == `PDTLP_VEC_RESET && q.vec_valid && q.imask && q.mask && !q.req))
    else $error("Reset state wrong");
  AST_VEC_SLVERR: assert property (@(posedge aclk) disable iff (!aresetn)
    (wr_go && q.awa[7:2] == `PDTLP_OFF_VECTOR >> 2) |=> q.bresp == `PDTLP_RESP_SLVERR)
    else $error("Vector write not refused");
  AST_BVALID_HOLD: assert property (@(posedge aclk) disable iff (!aresetn)
    (q.bvalid && !s_axi_bready) |=> q.bvalid)
    else $error("Write response dropped");
  AST_RVALID_HOLD: assert property (@(posedge aclk) disable iff (!aresetn)
    (q.rvalid && !s_axi_rready) |=> q.rvalid)
    else $error("Read response dropped");
endmodule

// [shared/pdtlp_consts.svh]
/*
  Constants for the prescaled down timer: register offsets, field positions,
  reset values and vector addresses. Assumes inclusion by bare name.
*/
`ifndef PDTLP_CONSTS_SVH
`define PDTLP_CONSTS_SVH
`define PDTLP_OFF_CONTROL      8'h00
`define PDTLP_OFF_COUNTER      8'h04
`define PDTLP_OFF_CORE         8'h08
`define PDTLP_OFF_VECTOR       8'h0C
`define PDTLP_BIT_REQ          7
`define PDTLP_BIT_MASK         6
`define PDTLP_BIT_SRC          5
`define PDTLP_BIT_PIN          4
`define PDTLP_BIT_PCLR         3
`define PDTLP_CORE_STOP        0
`define PDTLP_CORE_WAIT        1
`define PDTLP_CORE_IMASK       2
`define PDTLP_CORE_SWI         3
`define PDTLP_CORE_EXTREQ      4
`define PDTLP_CORE_ACK         5
`define PDTLP_VEC_WAIT_TIMER   12'h07F6
`define PDTLP_VEC_TIMER        12'h07F8
`define PDTLP_VEC_EXT          12'h07FA
`define PDTLP_VEC_SWI          12'h07FC
`define PDTLP_VEC_RESET        12'h07FE
`define PDTLP_RST_MASK         1'b1
`define PDTLP_RST_REQ          1'b0
`define PDTLP_RST_IMASK        1'b1
`define PDTLP_RESP_OKAY        2'b00
`define PDTLP_RESP_SLVERR      2'b10
`endif

// [shared/pdtlp_pkg.sv]
/*
  Types for the prescaled down timer. Assumes pdtlp_consts.svh for numbers.
*/
package pdtlp_pkg;
  typedef enum logic [1:0] {
    PDTLP_RUN  = 2'b00,
    PDTLP_WAIT = 2'b01,
    PDTLP_STOP = 2'b11
  } pdtlp_mode_type;

  typedef struct packed {
    logic           awv;
    logic [7:0]     awa;
    logic           wv;
    logic [31:0]    wd;
    logic [3:0]     ws;
    logic           bvalid;
    logic [1:0]     bresp;
    logic           rvalid;
    logic [31:0]    rdata;
    logic [1:0]     rresp;
    logic           req;
    logic           mask;
    logic           src;
    logic           pin_en;
    logic [2:0]     div;
    logic [6:0]     presc;
    logic [7:0]     count;
    logic           imask;
    logic           ext_pend;
    logic           swi_pend;
    logic [11:0]    vector;
    logic           vec_valid;
    pdtlp_mode_type mode;
    logic           pin_s1;
    logic           pin_s2;
    logic           pin_s3;
  } pdtlp_state_type;
endpackage

// [sim/pdtlp_pin_src.sv]
/*
  Timer pin source standing in for the external event line.
  Assumes the bench clock; the pin idles high between events.
*/
module pdtlp_pin_src (
  // Clock
  input  wire logic aclk,
  // Pin
  output logic      timer_pin
);
  timeunit 1ns;
  timeprecision 1ns;
  initial timer_pin = 1'b1;
  // Four clocks per phase so the two-flop synchroniser never misses an edge
  task automatic falls(input int n);
    repeat (n) begin
      repeat (4) @(posedge aclk);
      timer_pin <= 1'b0;
      repeat (4) @(posedge aclk);
      timer_pin <= 1'b1;
    end
  endtask
  task automatic level(input logic l);
    @(posedge aclk);
    timer_pin <= l;
  endtask
endmodule

// [sim/tb_top.sv]
/*
  Self-checking bench for the prescaled down timer.
  Assumes the design files and the pin source model; one 25 MHz clock.
*/
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic        aclk, aresetn, awv, wv, bre, arv, rre, pin;
  logic [7:0]  awa, ara;
  logic [31:0] wd, rv, rdata;
  logic [3:0]  ws;
  logic [1:0]  bresp, rresp, resp;
  logic        awr, wrd, bv, arr, rvl, irq, vv, run;
  logic [11:0] vec;
  int          fails, cmp_count, c, v;

  pdtlp_timer i_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(awv), .s_axi_awready(awr),
    .s_axi_awaddr(awa), .s_axi_wvalid(wv), .s_axi_wready(wrd), .s_axi_wdata(wd), .s_axi_wstrb(ws),
    .s_axi_bvalid(bv), .s_axi_bready(bre), .s_axi_bresp(bresp), .s_axi_arvalid(arv),
    .s_axi_arready(arr), .s_axi_araddr(ara), .s_axi_rvalid(rvl), .s_axi_rready(rre),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .timer_pin(pin), .timer_irq(irq),
    .irq_vector(vec), .irq_vector_valid(vv), .core_clock_run(run));
  pdtlp_pin_src i_pin (.aclk(aclk), .timer_pin(pin));

  initial begin
    aclk = 1'b0;
    forever #20 aclk = ~aclk;
  end

  task automatic chk(input logic [31:0] s, e);
    cmp_count++;
    if (s !== e) begin
      fails++;
      $display("unexpected at %0t: saw %h want %h", $time, s, e);
    end
  endtask
  task automatic give_verdict();
    if (fails == 0 && cmp_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic lost();
    fails++;
    $display("unexpected at %0t: no answer", $time);
    give_verdict();
  endtask
  // Handshakes are judged at the falling edge, where inputs and ready are settled
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic ah, wh, bh;
    int   n;
    @(posedge aclk);
    awv <= 1'b1; wv <= 1'b1; awa <= a; wd <= d; bre <= 1'b1;
    for (n = 0; n < 60; n++) begin
      @(negedge aclk);
      ah = awv && awr; wh = wv && wrd; bh = bv && bre; resp = bresp;
      @(posedge aclk);
      if (ah) awv <= 1'b0;
      if (wh) wv <= 1'b0;
      if (bh) begin
        bre <= 1'b0;
        break;
      end
    end
    if (n == 60) lost();
  endtask
  task automatic rd(input logic [7:0] a);
    logic ah, rh;
    int   n;
    @(posedge aclk);
    arv <= 1'b1; ara <= a; rre <= 1'b1;
    for (n = 0; n < 60; n++) begin
      @(negedge aclk);
      ah = arv && arr; rh = rvl && rre; rv = rdata;
      @(posedge aclk);
      if (ah) arv <= 1'b0;
      if (rh) begin
        rre <= 1'b0;
        break;
      end
    end
    if (n == 60) lost();
  endtask
  task automatic wait_vec(input logic [11:0] e);
    int n;
    for (n = 0; n < 600; n++) begin
      @(negedge aclk);
      if (vv === 1'b1) break;
    end
    if (n == 600) lost();
    chk(vec, e);
  endtask
  // Clear flag, mask timer, acknowledge vector, open the global mask
  task automatic ack();
    wr(8'h00, 32'h60);
    wr(8'h08, 32'h20);
  endtask

  initial begin
    {awv, wv, bre, arv, rre} = '0;
    awa = 8'h00; ara = 8'h00; wd = 32'h0; ws = 4'h1; aresetn = 1'b0;
    fails = 0; cmp_count = 0;
    v = $urandom(96470);
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    // Count is unknown at power-up; give it a value before anything counts
    wr(8'h04, 32'h0);
    rd(8'h00); chk(rv[7:6], 2'b01);
    rd(8'h0C); chk(rv[12:0], 13'h17FE);
    rd(8'h08); chk(rv[3], 1'b1);
    wr(8'h10, 32'h0); chk(resp, 2'b10);
    ack();
    v = $urandom_range(255);
    wr(8'h00, 32'h60); wr(8'h04, v);
    repeat ($urandom_range(40, 10)) @(posedge aclk);
    rd(8'h04); chk(rv, v);
    rd(8'h04); chk(rv, v);
    for (int d = 0; d < 8; d++) begin
      wr(8'h00, 32'h60); wr(8'h04, 32'h1); wr(8'h00, 32'h08 | d);
      for (c = 0; c < 300; c++) begin
        @(negedge aclk);
        if (irq === 1'b1) break;
      end
      chk(c + 3 >= (1 << d) && c <= (1 << d) + 4, 1'b1);
      wait_vec(12'h7F8);
      rd(8'h00); chk(rv[7], 1'b1);
      if (d == 0) begin
        rd(8'h04); chk(rv[7], 1'b1);
      end
      ack();
    end
    wr(8'h00, 32'h60); wr(8'h04, 32'h1); wr(8'h00, 32'h48);
    repeat (20) @(negedge aclk);
    chk(irq, 1'b0);
    rd(8'h00); chk(rv[7], 1'b1);
    wr(8'h00, 32'h60); rd(8'h00); chk(rv[7:0], 8'h60);
    // Gated mode: pin low holds the count, pin high lets clocks through
    i_pin.level(1'b0); wr(8'h00, 32'h58); wr(8'h04, 100);
    repeat (10) @(posedge aclk);
    rd(8'h04); chk(rv, 100);
    i_pin.level(1'b1); repeat (19) @(posedge aclk);
    i_pin.level(1'b0); repeat (6) @(posedge aclk);
    rd(8'h04); v = 100 - rv; chk(v >= 18 && v <= 22, 1'b1);
    i_pin.level(1'b1); wr(8'h00, 32'h78); wr(8'h04, 50); i_pin.falls(5);
    repeat (4) @(posedge aclk);
    rd(8'h04); chk(rv, 45);
    wr(8'h00, 32'h60); wr(8'h04, 40); wr(8'h00, 32'h08); wr(8'h08, 32'h02);
    @(negedge aclk); chk(run, 1'b0);
    rd(8'h08); chk(rv[3], 1'b0);
    wait_vec(12'h7F6);
    ack();
    wr(8'h08, 32'h04); wr(8'h00, 32'h80);
    @(negedge aclk); chk(irq, 1'b0);
    wr(8'h08, 32'h12); wait_vec(12'h7FA);
    wr(8'h08, 32'h20); wait_vec(12'h7F8);
    ack();
    wr(8'h08, 32'h04); wr(8'h08, 32'h0C); wait_vec(12'h7FC);
    ack();
    wr(8'h00, 32'h08); wr(8'h04, 200); wr(8'h08, 32'h01);
    rd(8'h00); chk(rv[7:6], 2'b01);
    rd(8'h04); v = rv; repeat (10) @(posedge aclk);
    rd(8'h04); chk(rv, v);
    rd(8'h08); chk(rv[3:0], 4'h3);
    wr(8'h08, 32'h10); wait_vec(12'h7FA);
    ack();
    wr(8'h00, 32'h3D); aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    rd(8'h00); chk(rv[7:0], 8'h75);
    give_verdict();
  end
endmodule
